/* logic/epce_top.sv */
// epp cycle engine: host register port to epp strobe cycles
//
// Strobed register access and the address map were left to the implementer.
module epce_top
  import epce_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [epce_pkg::BUS_ADDR_W_M1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic iochrdy_o,
  input wire logic [7:0] port_data_bus_i,
  output logic [7:0] port_data_bus_o,
  output logic port_data_bus_oe_o,
  output logic port_direction_out_o,
  output logic write_n_o,
  output logic data_strobe_n_o,
  output logic addr_strobe_n_o,
  output logic strobe_n_o,
  output logic autofd_n_o,
  output logic init_n_o,
  output logic slctin_n_o,
  input wire logic wait_n_i,
  input wire logic peripheral_interrupt_in_i,
  output logic peripheral_interrupt_out_o,
  output logic peripheral_reset_out_n_o,
  input wire logic error_status_in_i,
  input wire logic selected_status_in_i,
  input wire logic paper_end_in_i,
  input wire logic ack_n_i,
  input wire logic busy_i
);
  // address map: 0..7 hold the port registers, 9 holds the mode register
  // engine state: cycle phase, the two bytes it moves, the spp control copy,
  // the mode bits and the sticky timeout flag
  // rdata is cleared every cycle unless a read is being answered, so a stale
  // byte never shows on the host bus
  typedef struct packed {
    epce_state_e state;
    logic [7:0] data_out;
    logic [7:0] epp_rd;
    logic [5:0] ctrl;
    logic [1:0] mode;
    logic timeout;
    logic is_addr;
    logic is_read;
    logic [7:0] rdata;
  } epce_s;
  epce_s st_q, st_d;
  // the reset synchroniser runs on the raw reset, so it lives outside the struct
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic wd_abort;
  logic host_rd_epp;
  logic host_wr_epp;
  logic epp_sel;
  logic epp_on;
  logic v19;
  epce_link_if link ();

  // reset release through two flops, the only asynchronous path
  // only the second flop is read, so a late release never reaches the engine
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // watchdog runs while a cycle waits on the peripheral, and in 1.7 also while the host still holds its strobe
  // in 1.7 a hung peripheral therefore can never lock the host bus for good; in 1.9 a held host strobe restarts the cycle and ready stays low
  epce_watchdog u_dog (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .link(link.dog)
  );

  // decode helper shared by reads and writes
  // index 8 and above never reach the epp ports
  function automatic logic is_epp_port(input logic [3:0] a);
    is_epp_port = (a[3] == 1'b0) && (a[2:0] >= OFS_EPP_ADDR);
  endfunction : is_epp_port

  // mode bits are read straight from the register
  // switching mode in mid-cycle is not guarded, software must wait for idle
  assign epp_on = st_q.mode[MODE_EPP];
  assign v19 = st_q.mode[MODE_V19];
  assign epp_sel = epp_on && is_epp_port(addr_i);
  assign host_rd_epp = rd_i && epp_sel;
  assign host_wr_epp = wr_i && epp_sel;
  assign wd_abort = link.expired;

  // the 1.9 engine treats a strobe as a full cycle; 1.7 holds while strobe high
  // a new epp request is only taken in idle, so a host strobe that is still
  // high after hold would start a second cycle: the host must drop it once
  // ready goes high
  // register accesses below run beside the engine and never stall it
  always_comb begin
    st_d = st_q;
    st_d.rdata = BYTE_ZERO;
    link.run = 1'b0;
    case (st_q.state)
      EPCE_IDLE: begin
        if (host_rd_epp || host_wr_epp) begin
          st_d.is_addr = (addr_i[2:0] == OFS_EPP_ADDR);
          st_d.is_read = host_rd_epp;
          if (host_wr_epp) begin
            st_d.data_out = wdata_i;
          end
          if (v19) begin
            st_d.state = EPCE_WAIT_LOW;
          end else begin
            st_d.state = EPCE_STROBE;
          end
        end
      end
      EPCE_WAIT_LOW: begin
        link.run = 1'b1;
        if (!wait_n_i) begin
          st_d.state = EPCE_STROBE;
        end
      end
      EPCE_STROBE: begin
        link.run = 1'b1;
        if (v19 && wait_n_i) begin
          st_d.epp_rd = port_data_bus_i;
          // the byte also goes straight to the host side, so it stands while
          // ready is high in the finish cycle
          st_d.rdata = st_q.is_read ? port_data_bus_i : BYTE_ZERO;
          st_d.state = EPCE_FINISH;
        end else if (!v19 && (rd_i || wr_i) == 1'b0 && wait_n_i) begin
          if (st_q.is_read) begin
            st_d.epp_rd = port_data_bus_i;
          end
          st_d.state = EPCE_FINISH;
        end
        // 1.7 reads show the port byte live while the host still holds
        // its read strobe, because the host takes the byte before it lets go
        if (!v19 && st_q.is_read && wait_n_i) begin
          st_d.rdata = port_data_bus_i;
        end
      end
      EPCE_FINISH: begin
        if (st_q.is_read) begin
          st_d.rdata = st_q.epp_rd;
        end
        st_d.state = EPCE_HOLD;
      end
      EPCE_HOLD: begin
        st_d.state = EPCE_IDLE;
      end
      default: begin
        st_d.state = EPCE_IDLE;
      end
    endcase
    if (wd_abort) begin
      st_d.timeout = 1'b1;
      st_d.state = EPCE_IDLE;
    end
    // register writes, and status read clears the timeout flag
    // writes to the data register also load the byte that a later epp write
    // would replace, the two share one holding register
    if (wr_i && !addr_i[3]) begin
      if (addr_i[2:0] == OFS_CONTROL) begin
        st_d.ctrl = wdata_i[5:0];
      end else if (addr_i[2:0] == OFS_DATA) begin
        st_d.data_out = wdata_i;
      end
    end else if (wr_i && addr_i[3] && addr_i[2:0] == OFS_MODE_HI) begin
      st_d.mode = wdata_i[1:0];
    end
    if (rd_i && !addr_i[3] && !epp_sel) begin
      if (addr_i[2:0] == OFS_DATA) begin
        st_d.rdata = st_q.ctrl[CTL_DIR] ? port_data_bus_i : st_q.data_out;
      end else if (addr_i[2:0] == OFS_STATUS) begin
        st_d.rdata = {~busy_i, ack_n_i, paper_end_in_i, selected_status_in_i,
                      error_status_in_i, 2'h0, st_q.timeout};
        // set wins over the clear
        if (!wd_abort) begin
          st_d.timeout = 1'b0;
        end
      end else if (addr_i[2:0] == OFS_CONTROL) begin
        st_d.rdata = {2'h0, st_q.ctrl};
      end
    end else if (rd_i && addr_i[3] && addr_i[2:0] == OFS_MODE_HI) begin
      st_d.rdata = {6'h00, st_q.mode};
    end
  end

  // main state register
  // every field is reset to a constant, so the engine leaves reset idle
  // with the spp outputs at their control register defaults
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q.state <= EPCE_IDLE;
      st_q.data_out <= BYTE_ZERO;
      st_q.epp_rd <= BYTE_ZERO;
      st_q.ctrl <= CTL_RESET;
      st_q.mode <= MODE_RESET;
      st_q.timeout <= 1'b0;
      st_q.is_addr <= 1'b0;
      st_q.is_read <= 1'b0;
      st_q.rdata <= BYTE_ZERO;
    end else begin
      st_q.state <= st_d.state;
      st_q.data_out <= st_d.data_out;
      st_q.epp_rd <= st_d.epp_rd;
      st_q.ctrl <= st_d.ctrl;
      st_q.mode <= st_d.mode;
      st_q.timeout <= st_d.timeout;
      st_q.is_addr <= st_d.is_addr;
      st_q.is_read <= st_d.is_read;
      st_q.rdata <= st_d.rdata;
    end
  end

  logic busy_cyc;
  logic strobing;
  logic rd_cyc;
  logic ctl_dir;
  logic ctl_force_wr;
  logic ready_v19;
  logic ready_v17;

  // cycle phase decode shared by the pin logic below
  always_comb begin
    busy_cyc = (st_q.state != EPCE_IDLE);
    strobing = (st_q.state == EPCE_STROBE);
    rd_cyc = busy_cyc && st_q.is_read;
    ctl_dir = st_q.ctrl[CTL_DIR];
    ctl_force_wr = st_q.ctrl[CTL_STROBE];
  end

  // separate address and data strobes
  // both come from the state flop, so host inputs never glitch them
  always_comb begin
    addr_strobe_n_o = 1'b1;
    data_strobe_n_o = 1'b1;
    if (strobing) begin
      if (st_q.is_addr) begin
        addr_strobe_n_o = 1'b0;
      end else begin
        data_strobe_n_o = 1'b0;
      end
    end
  end

  always_comb begin
    write_n_o = 1'b0;
    port_direction_out_o = 1'b0;
    if (rd_cyc || ctl_dir) begin
      write_n_o = 1'b1;
      port_direction_out_o = 1'b1;
    end
    // control strobe bit forces nwrite asserted
    if (ctl_force_wr) begin
      write_n_o = 1'b0;
    end
  end

  // write byte on bus
  // the bus is only let go while the direction is read, so both sides never fight
  assign port_data_bus_oe_o = !port_direction_out_o;
  assign port_data_bus_o = st_q.data_out;

  // hold ready low in 1.9 cycles until the finish and hold states
  // ready is also pulled low in the idle cycle that takes the host strobe
  always_comb begin
    ready_v19 = (st_q.state == EPCE_FINISH) || (st_q.state == EPCE_HOLD);
    if (!busy_cyc && !(host_rd_epp || host_wr_epp)) begin
      ready_v19 = 1'b1;
    end
  end

  // until nwait rises or timeout
  // the abort leaves the strobe state, which releases ready on its own
  always_comb begin
    ready_v17 = 1'b1;
    if (strobing && !wait_n_i) begin
      ready_v17 = 1'b0;
    end
  end

  // ready is a handshake output, so it may come straight from logic
  assign iochrdy_o = v19 ? ready_v19 : ready_v17;

  // control register drives the spp outputs
  // strobe follows the control register strobe bit alone, not the cycle state
  assign strobe_n_o = !st_q.ctrl[CTL_STROBE];
  assign autofd_n_o = !st_q.ctrl[CTL_AUTOFD];
  // init is the one control output that is not inverted
  assign init_n_o = st_q.ctrl[CTL_INIT];
  assign slctin_n_o = !st_q.ctrl[CTL_SLCTIN];

  // interrupt pass through
  // no edge logic here: the host side does the edge detection
  assign peripheral_interrupt_out_o = peripheral_interrupt_in_i;

  // peripheral reset follows the synchronised reset
  // the peripheral stays in reset until the two flops have let go
  assign peripheral_reset_out_n_o = rst_n;
  assign rdata_o = st_q.rdata;
endmodule : epce_top

/* logic/epce_pkg.sv */
// shared constants and types for the epp cycle engine
package epce_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WDOG_US = 10;
  // longest time rounds down to whole cycles
  localparam int unsigned WDOG_CYC = (WDOG_US * (CLK_HZ / 1_000_000));
  localparam int unsigned WDOG_W = 10;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_CONTROL = 3'h2;
  localparam logic [2:0] OFS_EPP_ADDR = 3'h3;
  localparam logic [2:0] OFS_EPP_DATA0 = 3'h4;
  localparam logic [2:0] OFS_MODE = 3'h7;
  localparam logic [2:0] OFS_MODE_HI = 3'h1;
  localparam logic [3:0] BUS_ADDR_W_M1 = 4'h3;
  localparam int unsigned CTL_STROBE = 0;
  localparam int unsigned CTL_AUTOFD = 1;
  localparam int unsigned CTL_INIT = 2;
  localparam int unsigned CTL_SLCTIN = 3;
  localparam int unsigned CTL_IRQE = 4;
  localparam int unsigned CTL_DIR = 5;
  localparam logic [5:0] CTL_RESET = 6'h04;
  localparam int unsigned ST_TIMEOUT = 0;
  localparam int unsigned MODE_EPP = 0;
  localparam int unsigned MODE_V19 = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [2:0] {
    EPCE_IDLE,
    EPCE_WAIT_LOW,
    EPCE_STROBE,
    EPCE_FINISH,
    EPCE_HOLD
  } epce_state_e;
endpackage : epce_pkg

/* logic/epce_link_if.sv */
// carrier between the cycle engine and its watchdog
interface epce_link_if;
  logic run;
  logic expired;
  modport engine (output run, input expired);
  modport dog (input run, output expired);
endinterface : epce_link_if

/* logic/epce_watchdog.sv */
// watchdog timer that measures how long an epp cycle has run
module epce_watchdog
  import epce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  epce_link_if.dog link
);
  typedef struct packed {
    logic [WDOG_W-1:0] count;
    logic expired;
  } epce_dog_s;
  epce_dog_s st_q, st_d;

  // counts while run is high, restarts when run drops
  always_comb begin
    st_d = st_q;
    if (!link.run) begin
      st_d.count = '0;
      st_d.expired = 1'b0;
    end else if (st_q.count >= WDOG_W'(WDOG_CYC)) begin
      st_d.expired = 1'b1;
    end else begin
      st_d.count = st_q.count + WDOG_W'(1);
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.expired = st_q.expired;
endmodule : epce_watchdog

/* bench/epce_monitor.sv */
// checker for the epp cycle engine ports
module epce_monitor (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic iochrdy_o,
  input wire logic data_strobe_n_o,
  input wire logic addr_strobe_n_o,
  input wire logic write_n_o,
  input wire logic port_data_bus_oe_o,
  input wire logic port_direction_out_o,
  input wire logic wait_n_i,
  input wire logic peripheral_interrupt_in_i,
  input wire logic peripheral_interrupt_out_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic stb;
  logic [15:0] run_q;
  assign stb = !data_strobe_n_o || !addr_strobe_n_o;
  // strobe pulse length, so a stuck strobe shows without long repetition
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= stb ? run_q + 16'h0001 : 16'h0000;
    end
  end
  a_one_strobe: assert property (!(!data_strobe_n_o && !addr_strobe_n_o))
    else $error("both strobes low");
  a_irq_pass: assert property (peripheral_interrupt_out_o == peripheral_interrupt_in_i)
    else $error("interrupt not passed through");
  a_read_dir: assert property (stb && write_n_o |-> port_direction_out_o && !port_data_bus_oe_o)
    else $error("read strobe while driving bus");
  a_write_drive: assert property (stb && !write_n_o |-> port_data_bus_oe_o)
    else $error("write strobe without bus drive");
  a_wait_stretch: assert property (stb && !wait_n_i |-> !iochrdy_o)
    else $error("ready while wait low");
  a_host_release: assert property (stb && !rd_i && !wr_i |-> ##[0:2] !stb)
    else $error("strobe kept after host release");
  a_wdog_bound: assert property (run_q < 16'd520)
    else $error("strobe outlived watchdog");
  a_ready_release: assert property (!iochrdy_o |-> ##[1:520] iochrdy_o)
    else $error("ready held low too long");
endmodule : epce_monitor

bind epce_top epce_monitor u_mon (.*);

/* bench/epce_periph.sv */
// behavioural epp peripheral on the far side of the cable
module epce_periph (
  input wire logic clk_i,
  input wire logic stb_n_i,
  input wire logic write_n_i,
  input wire logic [7:0] bus_i,
  input wire logic stall_i,
  input wire logic [7:0] byte_i,
  output logic wait_n_o,
  output logic [7:0] drive_o,
  output logic [7:0] got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  initial begin
    cnt_q = 3'h0;
    wait_n_o = 1'b0;
    drive_o = 8'h00;
    got_o = 8'h00;
  end
  // byte first, wait raised three cycles later; stall keeps it low
  always @(posedge clk_i) begin
    if (!stb_n_i) begin
      cnt_q <= cnt_q + 3'h1;
      if (write_n_i) begin
        drive_o <= byte_i;
      end
      if (cnt_q == 3'h3 && !stall_i) begin
        wait_n_o <= 1'b1;
        got_o <= write_n_i ? got_o : bus_i;
      end
    end else begin
      // released lines toggle so a stale byte never reads back
      cnt_q <= 3'h0;
      drive_o <= ~drive_o;
      wait_n_o <= 1'b0;
    end
  end
endmodule : epce_periph

/* bench/tb_top.sv */
// self-checking bench for the epp cycle engine
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, wr, rd, wait_n, irq_in, stall, oe, a_low;
  logic rdy, dir, wr_n, dstb_n, astb_n, s_n, af_n, in_n, sl_n, irq_out, prst_n;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, pd_o, pd_i, pdrv, src, got, v;
  int bad_count = 0;
  int num_checks = 0;
  epce_top dut (.ref_clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .iochrdy_o(rdy), .port_data_bus_i(pd_i),
    .port_data_bus_o(pd_o), .port_data_bus_oe_o(oe), .port_direction_out_o(dir),
    .write_n_o(wr_n), .data_strobe_n_o(dstb_n), .addr_strobe_n_o(astb_n), .strobe_n_o(s_n),
    .autofd_n_o(af_n), .init_n_o(in_n), .slctin_n_o(sl_n), .wait_n_i(wait_n),
    .peripheral_interrupt_in_i(irq_in), .peripheral_interrupt_out_o(irq_out),
    .peripheral_reset_out_n_o(prst_n), .error_status_in_i(1'b1), .selected_status_in_i(1'b1),
    .paper_end_in_i(1'b0), .ack_n_i(1'b1), .busy_i(1'b0));
  epce_periph u_per (.clk_i(clk), .stb_n_i(dstb_n & astb_n), .write_n_i(wr_n), .bus_i(pd_o),
    .stall_i(stall), .byte_i(src), .wait_n_o(wait_n), .drive_o(pdrv), .got_o(got));
  // shared wire: the engine wins while its oe is high
  assign pd_i = oe ? pd_o : pdrv;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  // host strobe held while ready is low and for at least mn cycles
  task automatic host_cyc(input logic [3:0] a, input logic [7:0] d, input logic r,
                          input int mn);
    int n;
    n = 0;
    a_low = 1'b0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= r;
    wr <= !r;
    do begin
      @(negedge clk);
      n++;
      a_low |= (astb_n === 1'b0);
    end while (!(rdy === 1'b1 && n >= mn) && n < 1000);
    v = rdata;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 1000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : host_cyc
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {arst_n, wr, rd, irq_in, stall, addr, wdata, src} = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({4'h0, s_n, af_n, in_n, sl_n}, 8'h0f);
    chk({7'h0, prst_n}, 8'h01);
    reg_rd(4'h2);
    chk(v, 8'h04);
    reg_wr(4'h2, 8'h2b);
    chk({3'h0, dir, s_n, af_n, in_n, sl_n}, 8'h10);
    reg_wr(4'h2, 8'h04);
    chk({7'h0, dir}, 8'h00);
    reg_rd(4'h4);
    chk({v[6:0], dstb_n}, 8'h01);
    @(posedge clk);
    irq_in <= 1'b1;
    #1 chk({7'h0, irq_out}, 8'h01);
    // back-to-back 1.9 reads over the address and all data ports
    reg_wr(4'h9, 8'h03);
    for (int a = 3; a < 8; a++) begin
      src = 8'h5a ^ 8'(a);
      host_cyc(4'(a), 8'h00, 1'b1, 3);
      chk(v, 8'h5a ^ 8'(a));
      chk({7'h0, a_low}, {7'h0, a == 3});
    end
    reg_wr(4'h9, 8'h01);
    host_cyc(4'h4, 8'hc3, 1'b0, 12);
    chk(got, 8'hc3);
    reg_wr(4'h2, 8'h24);
    chk({6'h0, dir, oe}, 8'h02);
    src = 8'h96;
    host_cyc(4'h5, 8'h00, 1'b1, 12);
    chk(v, 8'h96);
    reg_wr(4'h2, 8'h04);
    stall = 1'b1;
    host_cyc(4'h4, 8'h11, 1'b0, 3);
    stall = 1'b0;
    reg_rd(4'h1);
    chk({7'h0, v[0]}, 8'h01);
    reg_rd(4'h1);
    chk({7'h0, v[0]}, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
